// File: hw/rps_rx_payload_sig.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps

// Contract
// - Control bit 7: 0 write, 1 read
// - Read command places indirect byte in data
// - Snapshot locks frame-one signaling for multiframe
// - Global trunk enable replaces every channel's ABCD
// - Global selector: channel, trunk, A-law, mu-law
// - Position bit keeps only upper nibble pair, in ESF only
// - Force enable drives all ABCD bits
// - Force level picks low or high
// - Function enable gates all payload functions
// - Freeze holds stored ABCD values
// - Debounce needs two identical codewords
// - Interrupt enable gates change flags onto output
// - Four-state mode stores only A and B
// - Sixteen-state mode stores A, B, C, D in ESF; superframe stores only A and B
// - Busy high during access; host waits
// - Buffer data register holds write/read byte
// - Per-channel change flags, write one clears
module rps_rx_payload_sig
(
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire logic [rps_pkg::AW-1:0]   reg_addr,
    input  wire logic [rps_pkg::DW-1:0]   reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [rps_pkg::DW-1:0]   reg_rdata,
    input  wire logic                     frame_sync,
    input  wire logic                     fmt_esf,
    input  wire logic [4:0]               frame_num,
    input  wire logic [4:0]               chan_num,
    input  wire logic                     rx_byte_valid,
    input  wire logic [7:0]               rx_byte,
    output logic      [7:0]               payload_out,
    output logic                          payload_out_valid,
    output logic      [3:0]               receive_signaling_out,
    output logic                          irq
);
    import rps_pkg::*;

    // ******************************************************
    // Storage
    // ******************************************************
    logic [7:0]               pl_ctrl_q;
    logic [7:0]               pl_data_q;
    logic [7:0]               cfg_q;
    logic [7:0]               en_q;
    logic [7:0]               sbc_q;
    logic [7:0]               sb_ctrl_q;
    logic [7:0]               sb_data_q;
    logic [NUM_CH-1:0]        flag_q;
    rps_acc_t                 pl_st_q;
    rps_acc_t                 sb_st_q;
    logic [2:0]               pl_cnt_q;
    logic [2:0]               sb_cnt_q;
    logic [NUM_CH-1:0][7:0]   chan_repl_mem_q;
    logic [NUM_CH-1:0][7:0]   trunk_data_mem_q;
    logic [NUM_CH-1:0][7:0]   strk_mem_q;
    logic [NUM_CH-1:0][7:0]   sb_mem_q;
    logic [NUM_CH-1:0][3:0]   acc_mem_q;
    logic [NUM_CH-1:0][3:0]   prev_mem_q;
    logic [NUM_CH-1:0][3:0]   snap_mem_q;
    logic [7:0]               rdata_q;
    logic [7:0]               pay_q;
    logic                     pay_vld_q;
    logic [3:0]               sig_q;
    logic                     irq_q;

    // ******************************************************
    // Register write decode
    // ******************************************************
    wire wr_pl_ctrl = reg_wr && (reg_addr == OFS_PL_CTRL);
    wire wr_pl_data = reg_wr && (reg_addr == OFS_PL_DATA);
    wire wr_cfg = reg_wr && (reg_addr == OFS_PL_CFG);
    wire wr_en = reg_wr && (reg_addr == OFS_PL_EN);
    wire wr_sbc = reg_wr && (reg_addr == OFS_SB_CFG);
    wire wr_sb_ctrl = reg_wr && (reg_addr == OFS_SB_CTRL);
    wire wr_sb_data = reg_wr && (reg_addr == OFS_SB_DATA);
    wire [7:0] clr0 = (reg_wr && reg_addr == OFS_FLAG0) ? reg_wdata : 8'h00;
    wire [7:0] clr1 = (reg_wr && reg_addr == OFS_FLAG1) ? reg_wdata : 8'h00;
    wire [7:0] clr2 = (reg_wr && reg_addr == OFS_FLAG2) ? reg_wdata : 8'h00;
    wire [NUM_CH-1:0] flag_clr = {clr2, clr1, clr0};

    // ******************************************************
    // Payload indirect access engine
    // ******************************************************
    // Group in bits 6:5 picks the table, low five bits the channel
    wire [1:0] pl_grp = pl_ctrl_q[6:5];
    wire [4:0] pl_low = pl_ctrl_q[4:0];
    wire pl_ok = (pl_grp != 2'h3) && (pl_low != 5'h00) && (pl_low <= CH_LAST);
    wire [4:0] pl_idx = pl_ok ? pl_low - 5'h01 : 5'h00;
    wire pl_busy = (pl_st_q == ACC_BUSY);
    wire pl_launch = wr_pl_ctrl && !pl_busy;
    wire pl_done = pl_busy && (pl_cnt_q == 3'h1);
    wire pl_rd_sel = pl_ctrl_q[RD_SEL_BIT];
    wire [7:0] pl_rd_byte = !pl_ok ? 8'h00 :
                            (pl_grp == 2'h0) ? chan_repl_mem_q[pl_idx] :
                            (pl_grp == 2'h1) ? trunk_data_mem_q[pl_idx] : strk_mem_q[pl_idx];

    // Engine walks idle to busy for a fixed access time
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pl_st_q <= ACC_IDLE;
            pl_cnt_q <= 3'h0;
        end
        else
        begin
            case (pl_st_q)
                ACC_IDLE:
                begin
                    if (pl_launch)
                    begin
                        pl_st_q <= ACC_BUSY;
                        pl_cnt_q <= ACCESS_CYC;
                    end
                end
                default:
                begin
                    pl_cnt_q <= pl_cnt_q - 3'h1;
                    if (pl_done)
                        pl_st_q <= ACC_IDLE;
                end
            endcase
        end
    end

    // ******************************************************
    // Signaling buffer indirect access engine
    // ******************************************************
    wire [4:0] sb_low = sb_ctrl_q[4:0];
    wire sb_ok = (sb_ctrl_q[6:5] == 2'h0) && (sb_low != 5'h00) && (sb_low <= CH_LAST);
    wire [4:0] sb_idx = sb_ok ? sb_low - 5'h01 : 5'h00;
    wire sb_busy = (sb_st_q == ACC_BUSY);
    wire sb_launch = wr_sb_ctrl && !sb_busy;
    wire sb_done = sb_busy && (sb_cnt_q == 3'h1);
    wire sb_rd_sel = sb_ctrl_q[RD_SEL_BIT];
    wire [7:0] sb_rd_byte = sb_ok ? sb_mem_q[sb_idx] : 8'h00;

    // Same timing as the payload engine so software treats both alike
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sb_st_q <= ACC_IDLE;
            sb_cnt_q <= 3'h0;
        end
        else
        begin
            case (sb_st_q)
                ACC_IDLE:
                begin
                    if (sb_launch)
                    begin
                        sb_st_q <= ACC_BUSY;
                        sb_cnt_q <= ACCESS_CYC;
                    end
                end
                default:
                begin
                    sb_cnt_q <= sb_cnt_q - 3'h1;
                    if (sb_done)
                        sb_st_q <= ACC_IDLE;
                end
            endcase
        end
    end

    // ******************************************************
    // Direct registers
    // ******************************************************
    // Control words are frozen while busy so the access sees a stable target
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pl_ctrl_q <= CTRL_RST;
            sb_ctrl_q <= CTRL_RST;
            pl_data_q <= DATA_RST;
            sb_data_q <= DATA_RST;
            cfg_q <= CFG_RST;
            en_q <= EN_RST;
            sbc_q <= SBC_RST;
        end
        else
        begin
            if (pl_launch)
                pl_ctrl_q <= reg_wdata;
            if (sb_launch)
                sb_ctrl_q <= reg_wdata;
            if (pl_done && pl_rd_sel)
                pl_data_q <= pl_rd_byte;
            else if (wr_pl_data && !pl_busy)
                pl_data_q <= reg_wdata;
            if (sb_done && sb_rd_sel)
                sb_data_q <= sb_rd_byte;
            else if (wr_sb_data && !sb_busy)
                sb_data_q <= reg_wdata;
            if (wr_cfg)
                cfg_q <= reg_wdata & CFG_WMASK;
            if (wr_en)
                en_q <= reg_wdata & LOW_WMASK;
            if (wr_sbc)
                sbc_q <= reg_wdata & LOW_WMASK;
        end
    end

    // ******************************************************
    // Payload indirect tables
    // ******************************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            chan_repl_mem_q <= '0;
            trunk_data_mem_q <= '0;
            strk_mem_q <= '0;
        end
        else if (pl_done && !pl_rd_sel && pl_ok)
        begin
            if (pl_grp == 2'h0)
                chan_repl_mem_q[pl_idx] <= pl_data_q;
            else if (pl_grp == 2'h1)
                trunk_data_mem_q[pl_idx] <= pl_data_q;
            else
                strk_mem_q[pl_idx] <= pl_data_q;
        end
    end

    // ******************************************************
    // Signaling extraction decode
    // ******************************************************
    wire func_en = en_q[EN_FUNC_BIT];
    wire ch_ok = rx_byte_valid && (chan_num < CH_LAST);
    wire [4:0] ch_i = ch_ok ? chan_num : 5'h00;
    wire sbit = rx_byte[SIG_BIT_POS];
    // Superframe carries only A and B, so it always runs the four-state path
    wire sig16 = sbc_q[SB_SIXTEEN_BIT] && fmt_esf;
    wire fr_a = (frame_num == FR_SIG_A) || (!sig16 && frame_num == FR_SIG_C);
    wire fr_b = (frame_num == FR_SIG_B) || (!sig16 && frame_num == FR_SIG_D);
    wire fr_c = sig16 && (frame_num == FR_SIG_C);
    wire fr_d = sig16 && (frame_num == FR_SIG_D);
    wire fr_sig = fr_a || fr_b || fr_c || fr_d;
    wire mf_end = fmt_esf ? (frame_num == FR_SIG_D) : (frame_num == FR_SIG_B);
    wire [3:0] acc = acc_mem_q[ch_i];
    wire [3:0] cw = {fr_a ? sbit : acc[3], fr_b ? sbit : acc[2],
                     fr_c ? sbit : acc[1], fr_d ? sbit : acc[0]};
    wire [3:0] stored = sb_mem_q[ch_i][3:0];
    wire [3:0] cw_eff = sig16 ? cw : {cw[3:2], stored[1:0]};
    wire debounce_ok = !sbc_q[SB_DEBOUNCE_BIT] || (cw_eff == prev_mem_q[ch_i]);
    wire sb_upd = ch_ok && mf_end && frame_sync && func_en && !sbc_q[SB_FREEZE_BIT]
                  && debounce_ok && (cw_eff != stored);
    wire [NUM_CH-1:0] flag_set = sb_upd ? NUM_CH'(24'h000001 << ch_i) : '0;

    // Codeword assembly and debounce history
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            acc_mem_q <= '0;
            prev_mem_q <= '0;
            snap_mem_q <= '0;
        end
        else if (ch_ok)
        begin
            if (fr_sig)
                acc_mem_q[ch_i] <= cw;
            if (mf_end)
                prev_mem_q[ch_i] <= cw_eff;
            if (frame_num == FR_FIRST)
                snap_mem_q[ch_i] <= stored;
        end
    end

    // Buffer: indirect write placed last so software wins a same-cycle clash
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            sb_mem_q <= '0;
        else
        begin
            if (sb_upd)
                sb_mem_q[ch_i][3:0] <= cw_eff;
            if (sb_done && !sb_rd_sel && sb_ok)
                sb_mem_q[sb_idx] <= sb_data_q;
        end
    end

    // Change flags: a new change beats a clear in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            flag_q <= '0;
        else
            flag_q <= (flag_q & ~flag_clr) | flag_set;
    end

    // ******************************************************
    // Output selection
    // ******************************************************
    wire snap_on = cfg_q[CFG_SNAP_BIT] && frame_sync;
    wire [3:0] sig_src = snap_on ? snap_mem_q[ch_i] : stored;
    wire [3:0] sig_pos = (en_q[EN_POSN_BIT] && fmt_esf) ? {sig_src[3:2], 2'h0}
                                                       : sig_src;
    wire trunk = cfg_q[CFG_GTRK_BIT] || strk_mem_q[ch_i][STRK_BIT];
    wire [3:0] sig_trk = trunk ? strk_mem_q[ch_i][3:0] : sig_pos;
    wire [3:0] sig_fix = en_q[EN_FORCE_BIT] ? {4{en_q[EN_LEVEL_BIT]}} : sig_trk;
    wire [3:0] sig_d = func_en ? sig_fix : stored;
    wire [2:0] gsub = cfg_q[2:0];
    wire [2:0] repl = (gsub == REPL_CHAN) ? chan_repl_mem_q[ch_i][7:5] : gsub;
    wire [2:0] phase = 3'(frame_num - 5'h01);
    // Reserved codes fall through to the received byte untouched
    wire [7:0] pay_d = !func_en ? rx_byte :
                       (repl == REPL_TRUNK) ? trunk_data_mem_q[ch_i] :
                       (repl == REPL_ALAW) ? ALAW_MW[phase] :
                       (repl == REPL_MULAW) ? MULAW_MW[phase] : rx_byte;

    // Read mux; unmapped offsets and reserved bits read zero
    wire [7:0] rd_mux = (reg_addr == OFS_PL_STAT) ? {7'h00, pl_busy} :
                        (reg_addr == OFS_PL_CTRL) ? pl_ctrl_q :
                        (reg_addr == OFS_PL_DATA) ? pl_data_q :
                        (reg_addr == OFS_PL_CFG) ? cfg_q :
                        (reg_addr == OFS_PL_EN) ? en_q :
                        (reg_addr == OFS_SB_CFG) ? sbc_q :
                        (reg_addr == OFS_SB_STAT) ? {7'h00, sb_busy} :
                        (reg_addr == OFS_SB_CTRL) ? sb_ctrl_q :
                        (reg_addr == OFS_SB_DATA) ? sb_data_q :
                        (reg_addr == OFS_FLAG0) ? flag_q[7:0] :
                        (reg_addr == OFS_FLAG1) ? flag_q[15:8] :
                        (reg_addr == OFS_FLAG2) ? flag_q[23:16] : 8'h00;

    // Output flops
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rdata_q <= 8'h00;
            pay_q <= 8'h00;
            pay_vld_q <= 1'b0;
            sig_q <= 4'h0;
            irq_q <= 1'b0;
        end
        else
        begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
            pay_vld_q <= ch_ok;
            if (ch_ok)
            begin
                pay_q <= pay_d;
                sig_q <= sig_d;
            end
            irq_q <= sbc_q[SB_IRQ_BIT] && (|flag_q);
        end
    end

    assign reg_rdata = rdata_q;
    assign payload_out = pay_q;
    assign payload_out_valid = pay_vld_q;
    assign receive_signaling_out = sig_q;
    assign irq = irq_q;

    // ******************************************************
    // Checks
    // ******************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    busy_window_a: assert property (pl_launch |=> pl_busy [*2] ##1 !pl_busy)
        else $error("payload busy window wrong");
    busy_guard_a: assert property (wr_sb_ctrl && sb_busy |=> $stable(sb_ctrl_q))
        else $error("control changed while busy");
    read_data_a: assert property (pl_done && pl_rd_sel |=> pl_data_q == $past(pl_rd_byte))
        else $error("indirect read data wrong");
    irq_gate_a: assert property (!sbc_q[SB_IRQ_BIT] |=> !irq)
        else $error("interrupt while disabled");
    flag_keep_a: assert property (!reg_wr |=> (flag_q & $past(flag_q)) == $past(flag_q))
        else $error("change flag lost");
    force_out_a: assert property (ch_ok && func_en && en_q[EN_FORCE_BIT]
        |=> receive_signaling_out == {4{$past(en_q[EN_LEVEL_BIT])}})
        else $error("forced signaling wrong");
    trunk_data_a: assert property (ch_ok && func_en && gsub == REPL_TRUNK
        |=> payload_out == $past(trunk_data_mem_q[ch_i]))
        else $error("trunk data not applied");
    freeze_hold_a: assert property (sbc_q[SB_FREEZE_BIT] && !sb_done
        |=> $stable(sb_mem_q))
        else $error("frozen signaling changed");
    pass_off_a: assert property (ch_ok && !func_en |=> payload_out == $past(rx_byte))
        else $error("disabled unit altered payload");
endmodule

// File: pkg/rps_pkg.sv
package rps_pkg;

    // ******************************************************
    // Bus widths and channel geometry
    // ******************************************************
    localparam int AW = 8;
    localparam int DW = 8;
    localparam int NUM_CH = 24;
    localparam logic [4:0] CH_LAST = 5'h18;

    // ******************************************************
    // Register offsets
    // ******************************************************
    localparam logic [7:0] OFS_PL_STAT = 8'hcd;
    localparam logic [7:0] OFS_PL_CTRL = 8'hce;
    localparam logic [7:0] OFS_PL_DATA = 8'hcf;
    localparam logic [7:0] OFS_PL_CFG  = 8'hd0;
    localparam logic [7:0] OFS_PL_EN   = 8'hd1;
    localparam logic [7:0] OFS_SB_CFG  = 8'hd2;
    localparam logic [7:0] OFS_SB_STAT = 8'hd3;
    localparam logic [7:0] OFS_SB_CTRL = 8'hd4;
    localparam logic [7:0] OFS_SB_DATA = 8'hd5;
    localparam logic [7:0] OFS_FLAG0   = 8'hd6;
    localparam logic [7:0] OFS_FLAG1   = 8'hd7;
    localparam logic [7:0] OFS_FLAG2   = 8'hd8;

    // ******************************************************
    // Field positions
    // ******************************************************
    localparam int RD_SEL_BIT = 7;
    localparam int BUSY_BIT = 0;
    localparam int CFG_SNAP_BIT = 7;
    localparam int CFG_GTRK_BIT = 6;
    localparam int EN_POSN_BIT = 3;
    localparam int EN_FORCE_BIT = 2;
    localparam int EN_LEVEL_BIT = 1;
    localparam int EN_FUNC_BIT = 0;
    localparam int SB_FREEZE_BIT = 3;
    localparam int SB_DEBOUNCE_BIT = 2;
    localparam int SB_IRQ_BIT = 1;
    localparam int SB_SIXTEEN_BIT = 0;
    localparam int STRK_BIT = 4;
    localparam int SIG_BIT_POS = 0;

    // ******************************************************
    // Reset values and writable masks
    // ******************************************************
    localparam logic [7:0] CFG_RST = 8'h80;
    localparam logic [7:0] EN_RST = 8'h00;
    localparam logic [7:0] SBC_RST = 8'h01;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'hc7;
    localparam logic [7:0] LOW_WMASK = 8'h0f;

    // ******************************************************
    // Replacement codes, frames and patterns
    // ******************************************************
    localparam logic [2:0] REPL_CHAN = 3'h0;
    localparam logic [2:0] REPL_TRUNK = 3'h1;
    localparam logic [2:0] REPL_ALAW = 3'h2;
    localparam logic [2:0] REPL_MULAW = 3'h3;
    localparam logic [4:0] FR_FIRST = 5'h01;
    localparam logic [4:0] FR_SIG_A = 5'h06;
    localparam logic [4:0] FR_SIG_B = 5'h0c;
    localparam logic [4:0] FR_SIG_C = 5'h12;
    localparam logic [4:0] FR_SIG_D = 5'h18;
    localparam logic [7:0][7:0] ALAW_MW = {8'hb4, 8'ha1, 8'ha1, 8'hb4,
                                          8'h34, 8'h21, 8'h21, 8'h34};
    localparam logic [7:0][7:0] MULAW_MW = {8'h9e, 8'h8b, 8'h8b, 8'h9e,
                                           8'h1e, 8'h0b, 8'h0b, 8'h1e};

    // ******************************************************
    // Timing
    // ******************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACCESS_TIME_NS = 20;
    localparam logic [2:0] ACCESS_CYC =
        3'((ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic {ACC_IDLE, ACC_BUSY} rps_acc_t;

endpackage

// File: tb/rps_host.sv
`timescale 1ns/1ps

// ******************************
// Host processor bus model
// ******************************
module rps_host
(
    input  wire logic       clk_sys,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // Idle bus until the bench calls a task
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One-cycle write strobe; the bench loads data before control
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data are taken in the one cycle they stand
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask

    // No new indirect request until busy reads 0; bounded poll
    task automatic idle(input logic [7:0] a);
        logic [7:0] s;
        s = 8'h01;
        for (int i = 0; i < 8 && s[0] !== 1'b0; i++)
            rd(a, s);
    endtask
endmodule

// File: tb/rps_rx_payload_sig_tb_top.sv
`timescale 1ns/1ps

module rps_rx_payload_sig_tb_top;
    import rps_pkg::*;

    logic       clk_sys, rst_n, frame_sync, fmt_esf, rx_byte_valid;
    logic [4:0] frame_num, chan_num;
    logic [7:0] rx_byte, reg_addr, reg_wdata, reg_rdata, payload_out, v;
    logic       reg_wr, reg_rd, payload_out_valid, irq;
    logic [3:0] receive_signaling_out;
    int         miscompares = 0;
    int         n_checks = 0;

    rps_host h (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    rps_rx_payload_sig dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .frame_sync(frame_sync), .fmt_esf(fmt_esf), .frame_num(frame_num),
        .chan_num(chan_num), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
        .payload_out(payload_out), .payload_out_valid(payload_out_valid),
        .receive_signaling_out(receive_signaling_out), .irq(irq));

    // ******************************
    // Clock, compare and verdict
    // ******************************
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One received byte; outputs settle one cycle later
    task automatic byte_in(input logic [4:0] ch, input logic [4:0] fr, input logic [7:0] b);
        @(posedge clk_sys);
        chan_num <= ch;
        frame_num <= fr;
        rx_byte <= b;
        rx_byte_valid <= 1'b1;
        @(posedge clk_sys);
        rx_byte_valid <= 1'b0;
        #1;
        chk({7'h00, payload_out_valid}, 8'h01);
    endtask

    // One signaling multiframe of a channel, ABCD on frames 6,12,18,24
    task automatic mf_in(input logic [4:0] ch, input logic [3:0] abcd);
        byte_in(ch, FR_SIG_A, {7'h00, abcd[3]});
        byte_in(ch, FR_SIG_B, {7'h00, abcd[2]});
        byte_in(ch, FR_SIG_C, {7'h00, abcd[1]});
        byte_in(ch, FR_SIG_D, {7'h00, abcd[0]});
    endtask

    // ******************************
    // Scenarios
    // ******************************
    task automatic t_reset();
        h.rd(OFS_PL_CFG, v); chk(v, 8'h80);
        h.rd(OFS_PL_EN, v); chk(v, 8'h00);
        h.rd(OFS_SB_CFG, v); chk(v, 8'h01);
        h.rd(8'he0, v); chk(v, 8'h00);
        h.wr(OFS_PL_CFG, 8'hff);
        h.rd(OFS_PL_CFG, v); chk(v, 8'hc7);
        h.wr(OFS_PL_EN, 8'hf0);
        h.rd(OFS_PL_EN, v); chk(v, 8'h00);
    endtask

    task automatic t_indirect();
        h.wr(OFS_PL_DATA, 8'h5a);
        h.wr(OFS_PL_CTRL, 8'h21);
        h.rd(OFS_PL_STAT, v); chk(v, 8'h01);
        h.idle(OFS_PL_STAT);
        h.wr(OFS_PL_DATA, 8'h00);
        h.wr(OFS_PL_CTRL, 8'ha1);
        h.idle(OFS_PL_STAT);
        h.rd(OFS_PL_DATA, v); chk(v, 8'h5a);
    endtask

    task automatic t_replace();
        h.wr(OFS_PL_CFG, 8'h81);
        byte_in(5'h00, 5'h01, 8'h33); chk(payload_out, 8'h33);
        h.wr(OFS_PL_EN, 8'h01);
        byte_in(5'h00, 5'h01, 8'h33); chk(payload_out, 8'h5a);
        h.wr(OFS_PL_CFG, 8'h80);
        byte_in(5'h00, 5'h01, 8'h33); chk(payload_out, 8'h33);
        h.wr(OFS_PL_EN, 8'h07);
        byte_in(5'h01, 5'h02, 8'h00); chk({4'h0, receive_signaling_out}, 8'h0f);
        h.wr(OFS_PL_EN, 8'h05);
        byte_in(5'h01, 5'h02, 8'hff); chk({4'h0, receive_signaling_out}, 8'h00);
        h.wr(OFS_PL_EN, 8'h01);
    endtask

    // Signaling bits 1,0,1,1 on frames 6,12,18,24 of channel 3
    task automatic t_signal();
        h.wr(OFS_SB_CFG, 8'h03);
        frame_sync <= 1'b1;
        fmt_esf <= 1'b1;
        mf_in(5'h02, 4'hb);
        h.rd(OFS_FLAG0, v); chk(v, 8'h04);
        chk({7'h00, irq}, 8'h01);
        h.wr(OFS_SB_CTRL, 8'h83);
        // A control write while busy must be refused
        h.wr(OFS_SB_CTRL, 8'h81);
        h.idle(OFS_SB_STAT);
        h.rd(OFS_SB_CTRL, v); chk(v, 8'h83);
        h.rd(OFS_SB_DATA, v); chk(v, 8'h0b);
        h.wr(OFS_FLAG0, 8'h04);
        h.rd(OFS_FLAG0, v); chk(v, 8'h00);
        chk({7'h00, irq}, 8'h00);
    endtask

    // Milliwatt patterns, snapshot and two-bit position, ESF in sync
    task automatic t_modes();
        h.wr(OFS_PL_CFG, 8'h02);
        byte_in(5'h00, FR_FIRST, 8'h00); chk(payload_out, ALAW_MW[0]);
        h.wr(OFS_PL_CFG, 8'h83);
        byte_in(5'h02, FR_FIRST, 8'h00); chk(payload_out, MULAW_MW[0]);
        byte_in(5'h02, 5'h02, 8'h00); chk({4'h0, receive_signaling_out}, 8'h0b);
        h.wr(OFS_PL_EN, 8'h09);
        byte_in(5'h02, 5'h02, 8'h00); chk({4'h0, receive_signaling_out}, 8'h08);
    endtask

    // Debounce wants a repeat, freeze blocks it, four-state keeps A and B
    task automatic t_debounce();
        h.wr(OFS_SB_CFG, 8'h05);
        mf_in(5'h02, 4'h0);
        h.rd(OFS_FLAG0, v); chk(v, 8'h00);
        h.wr(OFS_SB_CFG, 8'h0d);
        mf_in(5'h02, 4'h0);
        h.rd(OFS_FLAG0, v); chk(v, 8'h00);
        h.wr(OFS_SB_CFG, 8'h05);
        mf_in(5'h02, 4'h0);
        h.rd(OFS_FLAG0, v); chk(v, 8'h04);
        h.wr(OFS_SB_CFG, 8'h00);
        mf_in(5'h02, 4'hf);
        h.wr(OFS_SB_CTRL, 8'h83);
        h.idle(OFS_SB_STAT);
        h.rd(OFS_SB_DATA, v); chk(v, 8'h0c);
    endtask

    // Watchdog far beyond the roughly 180 cycles the tests need
    initial
    begin
        #200us;
        miscompares++;
        finish_test();
    end

    initial
    begin
        rst_n = 1'b0;
        frame_sync = 1'b0;
        fmt_esf = 1'b0;
        frame_num = 5'h01;
        chan_num = 5'h00;
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_indirect();
        t_replace();
        t_signal();
        t_modes();
        t_debounce();
        finish_test();
    end
endmodule
